// ===== reset_source_and_delay_logic.v
// Combines the four reset sources into one stretched chip reset and an
// immediate port reset, and records which source caused each reset.
// Assumes sources arrive from outside the clock domain, fuses are static,
// and software reaches the registers over a plain strobe port.
//
// How it works
// - Chip reset holds I/O registers at initial values; release starts vector fetch.
// - Port reset rises at once when any source becomes active.
// - Port reset path is asynchronous and needs no running clock.
// - Delay counter starts only after every source has gone inactive.
// - Delay length is chosen by the clock select fuses.
// - Supply below power-on threshold asserts reset.
// - External pin low longer than minimum pulse length asserts reset.
// - Watchdog expiry resets only while the watchdog is enabled.
// - Brown-out resets only while its enable fuse is programmed.
// - Brown-out must persist about 2 us before it is accepted.
// - Supply rising past power-on threshold starts the delay counter.
// - Supply falling again reasserts reset at once, without delay.
// - Watchdog gives a one-clock pulse; counting starts at its falling edge.
// - Per-source flags; power-on clears others; software clears by writing zero.
`timescale 1ns/10ps
`include "reset_source_regs.vh"

module reset_source_and_delay_logic #(
  parameter [`DELAY_CNT_W-1:0] TOUT_CYC_0 = `TOUT_CYC_0,
  parameter [`DELAY_CNT_W-1:0] TOUT_CYC_1 = `TOUT_CYC_1,
  parameter [`DELAY_CNT_W-1:0] TOUT_CYC_2 = `TOUT_CYC_2,
  parameter [`DELAY_CNT_W-1:0] TOUT_CYC_3 = `TOUT_CYC_3
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       supply_below_pot,
  input  wire       reset_pin_n,
  input  wire       watchdog_timeout,
  input  wire       brownout_detector,
  input  wire       brownout_enable_fuse,
  input  wire       brownout_level_fuse,
  input  wire [3:0] clock_select_fuses,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  output reg        chip_reset,
  output reg        port_reset,
  output reg        reset_vector_fetch,
  output reg        watchdog_enable,
  output reg        brownout_level_select
);

  // Picks the time-out length for a clock select setting.
  function [`DELAY_CNT_W-1:0] timeout_cycles;
    input [3:0] sel;
    begin
      case (sel[1:0])
        2'h0:    timeout_cycles = TOUT_CYC_0;
        2'h1:    timeout_cycles = TOUT_CYC_1;
        2'h2:    timeout_cycles = TOUT_CYC_2;
        default: timeout_cycles = TOUT_CYC_3;
      endcase
    end
  endfunction

  // The minimum widths are worked out in nanoseconds and rounded up to whole
  // clocks; the counts fit the filter counter, so the cut keeps every bit.
  localparam integer             EXT_MIN_INT = `EXT_MIN_PULSE_CYC;
  localparam integer             BOD_MIN_INT = `BOD_MIN_LOW_CYC;
  localparam [`FILTER_CNT_W-1:0] EXT_MIN_CYC = EXT_MIN_INT[`FILTER_CNT_W-1:0];
  localparam [`FILTER_CNT_W-1:0] BOD_MIN_CYC = BOD_MIN_INT[`FILTER_CNT_W-1:0];

  // Delay sequencer states: held in reset, counting the time-out, running.
  localparam [1:0] ST_HOLD  = 2'h0;
  localparam [1:0] ST_COUNT = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  wire [9:0] raw_in;
  reg  [9:0] sync_a;
  reg  [9:0] sync_b;
  reg        wdog_seen;

  wire       por_level;
  wire       ext_level;
  wire       wdog_level;
  wire       bod_level;
  wire       bod_enabled;
  wire       bod_level_fuse;
  wire [3:0] clock_select_fuses_fuses;

  wire       ext_active;
  wire       bod_qualified;
  wire       bod_active;
  wire       wdog_pulse;
  wire       any_source;
  wire       raw_any;

  reg  [1:0]              state;
  reg  [1:0]              next_state;
  reg  [`DELAY_CNT_W-1:0] delay_cnt;
  reg  [`DELAY_CNT_W-1:0] next_delay_cnt;
  reg  [3:0]              flags;
  reg  [3:0]              next_flags;

  // Inversion before the first flop keeps every source active high.
  assign raw_in = {clock_select_fuses, brownout_level_fuse, brownout_enable_fuse,
                   brownout_detector, watchdog_timeout, ~reset_pin_n,
                   supply_below_pot};

  // Two flops per source; only the second is read, as the first may still be
  // settling from a metastable sample.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_a <= 10'h000;
      sync_b <= 10'h000;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  assign por_level      = sync_b[0];
  assign ext_level      = sync_b[1];
  assign wdog_level     = sync_b[2];
  assign bod_level      = sync_b[3];
  assign bod_enabled    = sync_b[4];
  assign bod_level_fuse = sync_b[5];
  assign clock_select_fuses_fuses    = sync_b[9:6];

  // The pin and the brown-out detector must stay active for their minimum
  // widths before they count as reset sources.
  min_width_filter #(
    .MIN_CYC (EXT_MIN_CYC)
  ) u_ext_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .level_in  (ext_level),
    .qualified (ext_active)
  );

  min_width_filter #(
    .MIN_CYC (BOD_MIN_CYC)
  ) u_bod_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .level_in  (bod_level),
    .qualified (bod_qualified)
  );

  // A brown-out counts only while its enable fuse is programmed.
  assign bod_active = bod_qualified & bod_enabled;

  // The watchdog may hold its time-out for several clocks; only its first
  // clock counts, so the reset pulse is always exactly one clock long.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wdog_seen <= 1'b0;
    end else begin
      wdog_seen <= wdog_level;
    end
  end

  assign wdog_pulse = wdog_level & ~wdog_seen & watchdog_enable;

  // All qualified sources are ORed into the one request for reset.
  assign any_source = por_level | ext_active | bod_active | wdog_pulse;

  // Unfiltered, unclocked view of the sources for the port reset.
  // The watchdog may hold its time-out far longer than the one-clock reset
  // it stands for; once the synchronised copy has seen it, its term drops so
  // that the port pins leave reset together with the chip reset.
  assign raw_any = supply_below_pot | ~reset_pin_n |
                   (brownout_detector & brownout_enable_fuse) |
                   (watchdog_timeout & watchdog_enable & ~wdog_seen);

  // Delay counter sequencing. Any source seen while counting sends the
  // sequencer back to hold, so the full time-out always follows the last
  // source to go inactive.
  always @* begin
    next_state     = state;
    next_delay_cnt = delay_cnt;
    case (state)
      ST_HOLD: begin
        if (!any_source) begin
          next_state     = ST_COUNT;
          next_delay_cnt = timeout_cycles(clock_select_fuses_fuses) - 20'h0_0001;
        end
      end
      ST_COUNT: begin
        if (any_source) begin
          next_state = ST_HOLD;
        end else if (delay_cnt == {`DELAY_CNT_W{1'b0}}) begin
          next_state = ST_RUN;
        end else begin
          next_delay_cnt = delay_cnt - 20'h0_0001;
        end
      end
      ST_RUN: begin
        if (any_source) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  // The chip reset is taken from the next state so that it changes on the
  // same edge as the sequencer, and the vector fetch strobe marks the one
  // clock in which the chip first runs.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state              <= ST_HOLD;
      delay_cnt          <= {`DELAY_CNT_W{1'b0}};
      chip_reset         <= 1'b1;
      reset_vector_fetch <= 1'b0;
    end else begin
      state              <= next_state;
      delay_cnt          <= next_delay_cnt;
      chip_reset         <= (next_state != ST_RUN);
      reset_vector_fetch <= (state == ST_COUNT) && (next_state == ST_RUN);
    end
  end

  // Set at once by any raw source, released in step with the chip reset.
  always @(posedge ref_clk or posedge raw_any) begin
    if (raw_any) begin
      port_reset <= 1'b1;
    end else if (!rst_n) begin
      port_reset <= 1'b1;
    end else begin
      // A raw source still high at this edge keeps the set branch in charge.
      port_reset <= (next_state != ST_RUN);
    end
  end

  // Reset cause flags: a source event wins over a software clear.
  // Software can only clear bits; writing a one leaves a flag as it is.
  // Flags survive a chip reset; apart from a power-on only rst_n and
  // software clear them.
  always @* begin
    next_flags = flags;
    if (reg_write && (reg_addr == `REG_FLAGS)) begin
      next_flags = flags & reg_wdata[3:0];
    end
    if (por_level) begin
      next_flags[`FLAG_WDOG_BIT] = 1'b0;
      next_flags[`FLAG_BOD_BIT]  = 1'b0;
      next_flags[`FLAG_EXT_BIT]  = 1'b0;
      next_flags[`FLAG_POR_BIT]  = 1'b1;
    end else begin
      if (ext_active) begin
        next_flags[`FLAG_EXT_BIT] = 1'b1;
      end
      if (bod_active) begin
        next_flags[`FLAG_BOD_BIT] = 1'b1;
      end
      if (wdog_pulse) begin
        next_flags[`FLAG_WDOG_BIT] = 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      flags <= `FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Control register and fuse-driven outputs. A power-on drops the watchdog
  // enable, so a fresh supply always starts with the watchdog off.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      watchdog_enable       <= `CONTROL_RESET;
      brownout_level_select <= 1'b0;
    end else begin
      brownout_level_select <= bod_level_fuse;
      if (por_level) begin
        watchdog_enable <= `CONTROL_RESET;
      end else if (reg_write && (reg_addr == `REG_CONTROL)) begin
        watchdog_enable <= reg_wdata[`CTRL_WDOG_EN_BIT];
      end
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `REG_FLAGS:   reg_rdata <= {4'h0, flags};
        `REG_CONTROL: reg_rdata <= {7'h00, watchdog_enable};
        `REG_STATUS:  reg_rdata <= {state, bod_enabled, wdog_pulse, bod_active,
                                    ext_active, por_level, chip_reset};
        `REG_FUSES:   reg_rdata <= {2'h0, bod_level_fuse, bod_enabled, clock_select_fuses_fuses};
        default:      reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // reset_source_and_delay_logic

// ===== reset_source_regs.vh
// Constants shared by the reset source and delay logic.
// Assumes a 50 MHz reference clock; the minimum pulse counts below are derived from it.
`ifndef RESET_SOURCE_REGS_VH
`define RESET_SOURCE_REGS_VH

`define CLK_PERIOD_NS        20
`define EXT_MIN_PULSE_NS     1500
`define EXT_MIN_PULSE_CYC    ((`EXT_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOD_MIN_LOW_NS       2000
`define BOD_MIN_LOW_CYC      ((`BOD_MIN_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_CNT_W         8

`define REG_FLAGS            4'h0
`define REG_CONTROL          4'h1
`define REG_STATUS           4'h2
`define REG_FUSES            4'h3

`define FLAG_POR_BIT         0
`define FLAG_EXT_BIT         1
`define FLAG_BOD_BIT         2
`define FLAG_WDOG_BIT        3
`define CTRL_WDOG_EN_BIT     0

`define FLAGS_RESET          4'h0
`define CONTROL_RESET        1'b0

`define DELAY_CNT_W          20
`define TOUT_CYC_0           20'h0_0010
`define TOUT_CYC_1           20'h0_1000
`define TOUT_CYC_2           20'h0_4000
`define TOUT_CYC_3           20'h1_0000

`endif

// ===== min_width_filter.v
// Qualifies a synchronised level: the output rises only after the input has
// stayed high for MIN_CYC consecutive clocks and drops as soon as it falls.
// Assumes level_in is already on ref_clk.
`timescale 1ns/10ps
`include "reset_source_regs.vh"

module min_width_filter #(
  parameter [`FILTER_CNT_W-1:0] MIN_CYC = 8'h01
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire level_in,
  output reg  qualified
);

  reg [`FILTER_CNT_W-1:0] held;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      held      <= {`FILTER_CNT_W{1'b0}};
      qualified <= 1'b0;
    end else if (!level_in) begin
      held      <= {`FILTER_CNT_W{1'b0}};
      qualified <= 1'b0;
    end else if (held != MIN_CYC) begin
      held      <= held + 8'h01;
      qualified <= (held + 8'h01 == MIN_CYC);
    end
  end

endmodule // min_width_filter

// ===== reset_delay_monitor.sv
// Checker for the reset source and delay logic ports.
// Assumes one clock and time-outs of at least four cycles.
`timescale 1ns/10ps
module reset_delay_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire supply_below_pot,
  input wire reset_pin_n,
  input wire watchdog_timeout,
  input wire brownout_detector,
  input wire brownout_enable_fuse,
  input wire watchdog_enable,
  input wire chip_reset,
  input wire port_reset,
  input wire reset_vector_fetch
);
  reg [7:0] low_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Saturating count of clocks the pin has stayed low.
  always @(posedge ref_clk) begin
    if (reset_pin_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  end
  property p_port_now;
    supply_below_pot || !reset_pin_n |-> port_reset;
  endproperty
  a_port_now: assert property (p_port_now) else $error("port reset late");
  property p_por_hold;
    supply_below_pot |-> ##4 chip_reset [*3];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("supply reset lost");
  property p_ext_long;
    low_cnt == 8'h55 |-> chip_reset;
  endproperty
  a_ext_long: assert property (p_ext_long) else $error("pin reset missing");
  property p_ext_short;
    $fell(reset_pin_n) && !chip_reset && !supply_below_pot |-> !chip_reset [*8];
  endproperty
  a_ext_short: assert property (p_ext_short) else $error("short pin taken");
  property p_quiet;
    (!chip_reset && !supply_below_pot && reset_pin_n && !watchdog_enable
      && !(brownout_detector && brownout_enable_fuse)) [*4] |=> !chip_reset;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset without source");
  property p_wdog;
    watchdog_enable && $rose(watchdog_timeout) && !chip_reset |-> ##[1:4] chip_reset;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
  property p_fetch;
    $fell(chip_reset) |-> reset_vector_fetch && !port_reset;
  endproperty
  a_fetch: assert property (p_fetch) else $error("release mismatch");
  property p_fetch_one;
    reset_vector_fetch |-> $past(chip_reset) ##1 !reset_vector_fetch;
  endproperty
  a_fetch_one: assert property (p_fetch_one) else $error("fetch pulse bad");
  c_release: cover property ($fell(chip_reset));
  c_ext: cover property (low_cnt == 8'h55);
  c_wdog: cover property (watchdog_enable && $rose(watchdog_timeout));
endmodule // reset_delay_monitor

bind reset_source_and_delay_logic reset_delay_monitor i_reset_delay_monitor (
  .ref_clk, .rst_n, .supply_below_pot, .reset_pin_n, .watchdog_timeout,
  .brownout_detector, .brownout_enable_fuse, .watchdog_enable, .chip_reset,
  .port_reset, .reset_vector_fetch
);

// ===== reset_sources_model.sv
// Model of the supply monitors, watchdog and external reset pin.
// Assumes the bench calls pulse; the pin idles high on its pull-up.
`timescale 1ns/10ps
module reset_sources_model (
  input  wire ref_clk,
  output reg  supply_below_pot,
  output reg  reset_pin_n,
  output reg  watchdog_timeout,
  output reg  brownout_detector
);
  initial begin
    supply_below_pot = 1'b0;
    reset_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
    brownout_detector = 1'b0;
  end
  // Source 0 supply, 1 pin, 2 watchdog, 3 brown-out, active for n clocks.
  task pulse(input [1:0] src, input integer n);
    begin
      @(posedge ref_clk);
      drive(src, 1'b1);
      repeat (n) @(posedge ref_clk);
      drive(src, 1'b0);
      @(posedge ref_clk);
    end
  endtask
  task drive(input [1:0] src, input v);
    begin
      case (src)
        2'h0: supply_below_pot <= v;
        2'h1: reset_pin_n <= ~v;
        2'h2: watchdog_timeout <= v;
        default: brownout_detector <= v;
      endcase
    end
  endtask
endmodule // reset_sources_model

// ===== reset_source_and_delay_logic_bench.sv
// Self-checking bench for the reset source and delay logic.
// Assumes short time-outs of 4, 6, 8 and 10 clocks.
`timescale 1ns/10ps
module reset_source_and_delay_logic_bench;
  localparam [19:0] STEP = 20'h0_0002;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         brownout_enable_fuse = 1'b0;
  reg         brownout_level_fuse = 1'b0;
  reg  [3:0]  clock_select_fuses = 4'h0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_write = 1'b0;
  reg         reg_read = 1'b0;
  reg  [7:0]  q;
  reg  [19:0] d;
  wire [7:0]  reg_rdata;
  wire        supply_below_pot, reset_pin_n, watchdog_timeout, brownout_detector;
  wire        chip_reset, port_reset, reset_vector_fetch, watchdog_enable;
  wire        brownout_level_select;
  integer     err_total = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     k;
  always #10 ref_clk = ~ref_clk;
  reset_sources_model i_reset_sources_model (
    .ref_clk, .supply_below_pot, .reset_pin_n, .watchdog_timeout, .brownout_detector);
  reset_source_and_delay_logic #(.TOUT_CYC_0(20'h0_0004), .TOUT_CYC_1(20'h0_0006),
    .TOUT_CYC_2(20'h0_0008), .TOUT_CYC_3(20'h0_000A)) i_reset_source_and_delay_logic (
    .ref_clk, .rst_n, .supply_below_pot, .reset_pin_n, .watchdog_timeout,
    .brownout_detector, .brownout_enable_fuse, .brownout_level_fuse,
    .clock_select_fuses, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .chip_reset, .port_reset, .reset_vector_fetch, .watchdog_enable,
    .brownout_level_select);
  task check(input [95:0] name, input [19:0] seen, input [19:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 q = reg_rdata;
    end
  endtask
  task wait_rel;
    begin
      d = 20'h0_0000;
      while (chip_reset !== 1'b0 && d < 20'h0_0100) begin
        @(posedge ref_clk);
        #1 d = d + 20'h0_0001;
      end
    end
  endtask
  task t_power_on(input [1:0] sel);
    begin
      @(posedge ref_clk);
      clock_select_fuses <= {2'b00, sel};
      i_reset_sources_model.pulse(2'h0, 6);
      #1 check("por_on", chip_reset, 1'b1);
      wait_rel;
      // Four clocks of base time-out plus two of synchroniser lag.
      check("delay", d, 20'h0_0006 + STEP * sel);
      check("fetch", reset_vector_fetch, 1'b1);
      rd(4'h0);
      check("por_flag", q, 8'h01);
      wr(4'h0, 8'h00);
      rd(4'h0);
      check("flag_clr", q, 8'h00);
    end
  endtask
  task t_ext;
    begin
      i_reset_sources_model.pulse(2'h1, 40);
      repeat (4) @(posedge ref_clk);
      #1 check("ext_short", chip_reset, 1'b0);
      i_reset_sources_model.pulse(2'h1, 90);
      #1 check("ext_long", chip_reset, 1'b1);
      check("port_hold", port_reset, 1'b1);
      wait_rel;
      check("port_rel", port_reset, 1'b0);
      rd(4'h0);
      check("ext_flag", q, 8'h02);
      wr(4'h0, 8'h00);
    end
  endtask
  task t_wdog;
    begin
      i_reset_sources_model.pulse(2'h2, 5);
      rd(4'h0);
      check("wdog_off", {q, chip_reset}, 20'h0_0000);
      wr(4'h1, 8'h01);
      rd(4'h1);
      check("wdog_en", q, 8'h01);
      i_reset_sources_model.pulse(2'h2, 40);
      rd(4'h0);
      check("wdog_rst", {q, chip_reset}, 20'h0_0010);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
    end
  endtask
  task t_bod;
    begin
      i_reset_sources_model.pulse(2'h3, 120);
      #1 check("bod_off", chip_reset, 1'b0);
      @(posedge ref_clk);
      brownout_enable_fuse <= 1'b1;
      brownout_level_fuse <= 1'b1;
      i_reset_sources_model.pulse(2'h3, 50);
      #1 check("bod_short", chip_reset, 1'b0);
      i_reset_sources_model.pulse(2'h3, 120);
      #1 check("bod_long", chip_reset, 1'b1);
      wait_rel;
      rd(4'h0);
      check("bod_flag", q, 8'h04);
      check("bod_lvl", brownout_level_select, 1'b1);
      rd(4'h3);
      check("fuses", q, 8'h33);
      i_reset_sources_model.pulse(2'h0, 6);
      wait_rel;
      rd(4'h0);
      check("por_wins", q, 8'h01);
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      results;
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 4; k = k + 1)
      t_power_on(k[1:0]);
    t_ext;
    t_wdog;
    t_bod;
    rd(4'hF);
    check("unmapped", q, 8'h00);
    results;
  end
endmodule // reset_source_and_delay_logic_bench
